/* File: logic/uvt_pkg.sv */
// Constants and types for the ULPI vendor tuning register bank.
package uvt_pkg;
  // Register addresses in the vendor range.
  localparam logic [5:0] A_VEND_LO = 6'h30;
  localparam logic [5:0] A_VEND_HI = 6'h3F;
  localparam logic [5:0] A_TRIM = 6'h31;
  localparam logic [5:0] A_CHG = 6'h32;
  localparam logic [5:0] A_HSET = 6'h33;
  localparam logic [5:0] A_IDC = 6'h36;
  localparam logic [5:0] A_IDC_SET = 6'h37;
  localparam logic [5:0] A_IDC_CLR = 6'h38;
  // Transmit command codes in the top two bits of the command byte.
  localparam logic [1:0] CMD_WR = 2'h2;
  localparam logic [1:0] CMD_RD = 2'h3;
  // Writable bits and reset values.
  localparam logic [7:0] TRIM_MASK = 8'h73;
  localparam logic [7:0] TRIM_RST = 8'h00;
  localparam logic [3:0] CHG_RST = 4'h0;
  localparam logic [3:0] HSET_RST = 4'h0;
  localparam logic [3:0] HSET_KEY = 4'hA;
  localparam logic [7:0] IDC_WMASK = 8'h57;
  localparam logic [7:0] IDC_RST = 8'h00;
  localparam logic [7:0] IDC_START_M = 8'h10;
  localparam logic [7:0] IDC_DONE_M = 8'h08;
  localparam logic [7:0] IDC_CODE_M = 8'h07;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] LS_SE0 = 2'h0;
  // Field positions and widths.
  localparam int SQ_LSB = 0;
  localparam int SQ_W = 2;
  localparam int BOOST_LSB = 4;
  localparam int BOOST_W = 3;
  localparam int CHG_SINK = 1;
  localparam int CHG_HOST = 3;
  localparam int LANES = 3;
  localparam int CODE_W = 3;
  localparam int IDC_START = 4;
  localparam int IDC_IRQ = 6;
  localparam int RXCMD_ALT = 7;
  // Conversion timing.
  localparam int CLK_PERIOD_NS = 50;
  localparam int CONV_TIME_NS = 282000;
  localparam int CONV_CYCLES =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  // Link access sequencer states.
  typedef enum logic [3:0] {
    ST_IDLE, ST_WR_ACK, ST_WR_DATA, ST_WR_STP,
    ST_RD_ACK, ST_RD_TURN, ST_RD_DATA, ST_RX_TURN, ST_RX_DATA
  } uvt_state_t;
endpackage : uvt_pkg

/* File: logic/uvt_conv_if.sv */
// Handshake between the register bank and the ID conversion engine.
`timescale 1ns/1ns
interface uvt_conv_if;
  logic start_pls;
  logic done_pls;
  logic busy;
  logic [2:0] code;
  modport eng (input start_pls, output done_pls, output busy,
    output code);
  modport ctl (output start_pls, input done_pls, input busy,
    input code);
endinterface : uvt_conv_if

/* File: logic/uvt_conv_engine.sv */
// ID resistor conversion timer that captures the measured code.
`timescale 1ns/1ns
module uvt_conv_engine #(
  parameter int CYCLES = uvt_pkg::CONV_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Synchronised measurement code
  input wire logic [2:0] meas_code,
  // Control handshake
  uvt_conv_if.eng cif
);
  localparam int CNT_W = uvt_pkg::CNT_W;
  logic [CNT_W-1:0] cnt_r;
  logic busy_r;
  logic done_r;
  logic [2:0] code_r;
  wire cnt_end = (cnt_r == '0);

  assign cif.done_pls = done_r;
  assign cif.busy = busy_r;
  assign cif.code = code_r;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      code_r <= 3'h0;
    end else begin
      done_r <= 1'b0;
      if (!busy_r && cif.start_pls) begin
        busy_r <= 1'b1;
        cnt_r <= CNT_W'(CYCLES - 1);
      end else if (busy_r && cnt_end) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
        code_r <= meas_code;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // End of count finishes the conversion.
  conv_end_a: assert property (
    @(posedge core_clk) disable iff (srst)
    busy_r && cnt_end |=> done_r && !busy_r)
    else $error("conversion did not finish at end of count");
endmodule : uvt_conv_engine

/* File: logic/uvt_regs.sv */
// ULPI vendor tuning register bank with link access sequencer.
// Functional notes
// - Compensation register at 31h, readable and writable.
// - Bits 1:0 scale squelch threshold 100, 83, 66.7, 50 percent.
// - Bits 6:4 raise high-speed drive from nominal to plus 25.7 percent.
// - Charger bit 3 swaps source, sink, probe, comparator to DM.
// - Comparator bit 4 is one only with voltage and line state 00.
// - Comparator state is mirrored to the carkit status register.
// - Headset audio mode enabled only by key 1010, default 0000.
// - Conversion register read at 36h-38h; write, set, clear there.
// - Bits 2:0 hold the measured ID resistance code.
// - Done flag bit 3 sets when a 282 us conversion ends.
// - Reading the code here clears done; carkit read does not.
// - Start bit 4 begins a conversion and self-clears at its end.
// - With bit 6 set, done raises alt_int in the RXCMD byte.
// - Interrupt enable is bit 6 OR the carkit enable.
// - Vendor range 30h-3Fh reached only by immediate ULPI access.
// - Carkit latch sets on enabled done rise, clears on read.
`timescale 1ns/1ns
module uvt_regs #(
  parameter int CONV_CYCLES = uvt_pkg::CONV_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // ULPI link pins
  input wire logic [7:0] ulpi_data_in,
  output logic [7:0] ulpi_data_out,
  output logic ulpi_data_oe,
  output logic ulpi_dir,
  output logic ulpi_nxt,
  input wire logic ulpi_stp,
  // Analogue status inputs
  input wire logic [1:0] line_state_raw,
  input wire logic dp_cmp_raw,
  input wire logic dm_cmp_raw,
  input wire logic [2:0] id_meas_code_raw,
  // Carkit register set
  input wire logic carkit_irq_en,
  input wire logic carkit_latch_rd,
  output logic charger_comparator_out,
  output logic [2:0] id_resistance_code,
  output logic id_measure_done,
  output logic id_measure_done_latch,
  // Analogue controls
  output logic [1:0] squelch_threshold_trim,
  output logic [2:0] hs_drive_boost,
  output logic [2:0] dp_lane_en,
  output logic [2:0] dm_lane_en,
  output logic charging_host_port_sel,
  output logic headset_audio_en
);
  function automatic logic idc_hit(input logic [5:0] a);
    idc_hit = (a >= uvt_pkg::A_IDC) && (a <= uvt_pkg::A_IDC_CLR);
  endfunction : idc_hit

  uvt_pkg::uvt_state_t st_r;
  uvt_pkg::uvt_state_t st_nxt;
  logic [5:0] addr_r;
  logic [7:0] wdata_r;
  logic [7:0] rdata_r;
  logic [7:0] trim_r;
  logic [3:0] chg_r;
  logic [3:0] hset_r;
  logic [7:0] idc_r;
  logic done_r;
  logic latch_r;
  logic alt_r;
  logic cmp_r;
  logic hset_en_r;
  logic [2:0] dp_r;
  logic [2:0] dm_r;
  logic nxt_r;
  logic dir_r;
  logic oe_r;
  logic [7:0] dout_r;
  logic start_pls_r;
  logic nxt_n;
  logic dir_n;
  logic oe_n;
  logic [7:0] dout_n;
  logic [1:0] ls_s1_r;
  logic [1:0] ls_s2_r;
  logic dp_s1_r;
  logic dp_s2_r;
  logic dm_s1_r;
  logic dm_s2_r;
  logic [2:0] code_s1_r;
  logic [2:0] code_s2_r;
  logic [2:0] dp_nxt;
  logic [2:0] dm_nxt;

  uvt_conv_if cif ();

  uvt_conv_engine #(
    .CYCLES(CONV_CYCLES)
  ) u_eng (
    .core_clk(core_clk),
    .srst(srst),
    .meas_code(code_s2_r),
    .cif(cif)
  );

  // Command decode, only while the bus is ours and idle.
  wire in_idle = (st_r == uvt_pkg::ST_IDLE);
  wire [1:0] cmd_code = ulpi_data_in[7:6];
  wire cmd_wr = in_idle && (cmd_code == uvt_pkg::CMD_WR);
  wire cmd_rd = in_idle && (cmd_code == uvt_pkg::CMD_RD);
  wire cmd_any = cmd_wr || cmd_rd;
  wire wr_go = (st_r == uvt_pkg::ST_WR_STP) && ulpi_stp;
  wire rd_take = (st_r == uvt_pkg::ST_RD_ACK);
  wire rx_sent = (st_r == uvt_pkg::ST_RX_TURN);
  wire in_vend = (addr_r >= uvt_pkg::A_VEND_LO) &&
    (addr_r <= uvt_pkg::A_VEND_HI);

  wire wr_trim = wr_go && in_vend && (addr_r == uvt_pkg::A_TRIM);
  wire wr_chg = wr_go && in_vend && (addr_r == uvt_pkg::A_CHG);
  wire wr_hset = wr_go && in_vend && (addr_r == uvt_pkg::A_HSET);
  wire wr_idc = wr_go && idc_hit(addr_r);

  wire [7:0] trim_nxt = wr_trim ? (wdata_r & uvt_pkg::TRIM_MASK) : trim_r;
  wire [3:0] chg_nxt = wr_chg ? wdata_r[3:0] : chg_r;
  wire [3:0] hset_nxt = wr_hset ? wdata_r[3:0] : hset_r;

  wire [7:0] idc_hw = cif.done_pls ?
    ((idc_r & ~(uvt_pkg::IDC_START_M | uvt_pkg::IDC_CODE_M)) |
    {5'h0, cif.code}) : idc_r;
  wire [7:0] wmask = wdata_r & uvt_pkg::IDC_WMASK;
  wire [7:0] idc_wr_val = (addr_r == uvt_pkg::A_IDC) ? wmask :
    (addr_r == uvt_pkg::A_IDC_SET) ? (idc_hw | wmask) : (idc_hw & ~wmask);
  wire [7:0] idc_nxt = wr_idc ? idc_wr_val : idc_hw;
  wire start_nxt = idc_nxt[uvt_pkg::IDC_START] &&
    !idc_r[uvt_pkg::IDC_START];

  wire irq_en = idc_r[uvt_pkg::IDC_IRQ] || carkit_irq_en;
  wire done_rise = cif.done_pls && !done_r;
  wire rd_clr = rd_take && idc_hit(addr_r);
  wire done_nxt = cif.done_pls || (done_r && !rd_clr);
  wire latch_nxt = (done_rise && irq_en) || (latch_r && !carkit_latch_rd);
  wire alt_nxt = (done_rise && irq_en) || (alt_r && !rx_sent);

  wire cmp_sel = chg_r[uvt_pkg::CHG_HOST] ? dm_s2_r : dp_s2_r;
  wire cmp_nxt = chg_r[uvt_pkg::CHG_SINK] && cmp_sel &&
    (ls_s2_r == uvt_pkg::LS_SE0);

  for (genvar i = 0; i < uvt_pkg::LANES; i++) begin : g_lane
    assign dp_nxt[i] = chg_nxt[i] && !chg_nxt[uvt_pkg::CHG_HOST];
    assign dm_nxt[i] = chg_nxt[i] && chg_nxt[uvt_pkg::CHG_HOST];
  end

  // Read selection; unknown addresses answer zero.
  wire [7:0] chg_rd = {3'h0, cmp_r, chg_r};
  wire [7:0] hset_rd = {4'h0, hset_r};
  wire [7:0] idc_rd = done_r ? (idc_r | uvt_pkg::IDC_DONE_M) : idc_r;
  wire [7:0] rd_mux = !in_vend ? uvt_pkg::BYTE_ZERO :
    (addr_r == uvt_pkg::A_TRIM) ? trim_r :
    (addr_r == uvt_pkg::A_CHG) ? chg_rd :
    (addr_r == uvt_pkg::A_HSET) ? hset_rd :
    idc_hit(addr_r) ? idc_rd : uvt_pkg::BYTE_ZERO;
  wire [7:0] rxcmd = {alt_r, 5'h0, ls_s2_r};

  always_comb begin
    st_nxt = st_r;
    nxt_n = 1'b0;
    dir_n = dir_r;
    oe_n = 1'b0;
    dout_n = dout_r;
    case (st_r)
      uvt_pkg::ST_IDLE: begin
        if (cmd_wr) begin
          st_nxt = uvt_pkg::ST_WR_ACK;
          nxt_n = 1'b1;
        end else if (cmd_rd) begin
          st_nxt = uvt_pkg::ST_RD_ACK;
          nxt_n = 1'b1;
        end else if (alt_r) begin
          st_nxt = uvt_pkg::ST_RX_TURN;
          dir_n = 1'b1;
        end
      end
      uvt_pkg::ST_WR_ACK: begin
        st_nxt = uvt_pkg::ST_WR_DATA;
        nxt_n = 1'b1;
      end
      uvt_pkg::ST_WR_DATA: begin
        st_nxt = uvt_pkg::ST_WR_STP;
      end
      uvt_pkg::ST_WR_STP: begin
        if (ulpi_stp) begin
          st_nxt = uvt_pkg::ST_IDLE;
        end
      end
      uvt_pkg::ST_RD_ACK: begin
        st_nxt = uvt_pkg::ST_RD_TURN;
        dir_n = 1'b1;
      end
      uvt_pkg::ST_RD_TURN: begin
        st_nxt = uvt_pkg::ST_RD_DATA;
        oe_n = 1'b1;
        dout_n = rdata_r;
      end
      uvt_pkg::ST_RX_TURN: begin
        st_nxt = uvt_pkg::ST_RX_DATA;
        oe_n = 1'b1;
        dout_n = rxcmd;
      end
      uvt_pkg::ST_RD_DATA, uvt_pkg::ST_RX_DATA: begin
        st_nxt = uvt_pkg::ST_IDLE;
        dir_n = 1'b0;
      end
      default: begin
        st_nxt = uvt_pkg::ST_IDLE;
        dir_n = 1'b0;
      end
    endcase
  end

  // Analogue inputs are asynchronous and pass two flip-flops.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ls_s1_r <= 2'h0;
      ls_s2_r <= 2'h0;
      dp_s1_r <= 1'b0;
      dp_s2_r <= 1'b0;
      dm_s1_r <= 1'b0;
      dm_s2_r <= 1'b0;
      code_s1_r <= 3'h0;
      code_s2_r <= 3'h0;
    end else begin
      ls_s1_r <= line_state_raw;
      ls_s2_r <= ls_s1_r;
      dp_s1_r <= dp_cmp_raw;
      dp_s2_r <= dp_s1_r;
      dm_s1_r <= dm_cmp_raw;
      dm_s2_r <= dm_s1_r;
      code_s1_r <= id_meas_code_raw;
      code_s2_r <= code_s1_r;
    end
  end

  // Link side sequencer and captured bytes.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= uvt_pkg::ST_IDLE;
      nxt_r <= 1'b0;
      dir_r <= 1'b0;
      oe_r <= 1'b0;
      dout_r <= uvt_pkg::BYTE_ZERO;
      addr_r <= 6'h00;
      wdata_r <= uvt_pkg::BYTE_ZERO;
      rdata_r <= uvt_pkg::BYTE_ZERO;
    end else begin
      st_r <= st_nxt;
      nxt_r <= nxt_n;
      dir_r <= dir_n;
      oe_r <= oe_n;
      dout_r <= dout_n;
      if (cmd_any) addr_r <= ulpi_data_in[5:0];
      if (st_r == uvt_pkg::ST_WR_DATA) wdata_r <= ulpi_data_in;
      if (rd_take) rdata_r <= rd_mux;
    end
  end

  // Register state.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      trim_r <= uvt_pkg::TRIM_RST;
      chg_r <= uvt_pkg::CHG_RST;
      hset_r <= uvt_pkg::HSET_RST;
      idc_r <= uvt_pkg::IDC_RST;
      done_r <= 1'b0;
      latch_r <= 1'b0;
      alt_r <= 1'b0;
      start_pls_r <= 1'b0;
    end else begin
      trim_r <= trim_nxt;
      chg_r <= chg_nxt;
      hset_r <= hset_nxt;
      idc_r <= idc_nxt;
      done_r <= done_nxt;
      latch_r <= latch_nxt;
      alt_r <= alt_nxt;
      start_pls_r <= start_nxt;
    end
  end

  // Derived control flops.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmp_r <= 1'b0;
      hset_en_r <= 1'b0;
      dp_r <= 3'h0;
      dm_r <= 3'h0;
    end else begin
      cmp_r <= cmp_nxt;
      hset_en_r <= (hset_nxt == uvt_pkg::HSET_KEY);
      dp_r <= dp_nxt;
      dm_r <= dm_nxt;
    end
  end

  assign cif.start_pls = start_pls_r;
  assign ulpi_data_out = dout_r;
  assign ulpi_data_oe = oe_r;
  assign ulpi_dir = dir_r;
  assign ulpi_nxt = nxt_r;
  assign squelch_threshold_trim = trim_r[uvt_pkg::SQ_LSB +: uvt_pkg::SQ_W];
  assign hs_drive_boost = trim_r[uvt_pkg::BOOST_LSB +: uvt_pkg::BOOST_W];
  assign dp_lane_en = dp_r;
  assign dm_lane_en = dm_r;
  assign charging_host_port_sel = chg_r[uvt_pkg::CHG_HOST];
  assign headset_audio_en = hset_en_r;
  assign charger_comparator_out = cmp_r;
  assign id_resistance_code = idc_r[uvt_pkg::CODE_W-1:0];
  assign id_measure_done = done_r;
  assign id_measure_done_latch = latch_r;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  trim_write_a: assert property (
    wr_trim |=> squelch_threshold_trim == $past(wdata_r[1:0]) &&
    hs_drive_boost == $past(wdata_r[6:4]))
    else $error("compensation write not applied");

  lane_swap_a: assert property (
    dm_lane_en == (charging_host_port_sel ? chg_r[2:0] : 3'h0) &&
    dp_lane_en == (charging_host_port_sel ? 3'h0 : chg_r[2:0]))
    else $error("charger lanes not routed by host select");

  cmp_gate_a: assert property (
    !chg_r[uvt_pkg::CHG_SINK] |=> !charger_comparator_out)
    else $error("comparator reported while sink disabled");

  headset_key_a: assert property (
    headset_audio_en == (hset_r == uvt_pkg::HSET_KEY))
    else $error("headset mode does not follow key");

  code_load_a: assert property (
    cif.done_pls && !wr_idc |=> id_resistance_code == $past(cif.code))
    else $error("conversion code not captured");

  done_clear_a: assert property (
    rd_clr && !cif.done_pls |=> !id_measure_done)
    else $error("done flag not cleared by code read");

  start_clear_a: assert property (
    cif.done_pls && !wr_idc |=> !idc_r[uvt_pkg::IDC_START])
    else $error("start bit not cleared at conversion end");

  alt_rxcmd_a: assert property (
    in_idle && alt_r && !cmd_any |-> ##2
    (ulpi_data_oe && ulpi_dir && ulpi_data_out[uvt_pkg::RXCMD_ALT]))
    else $error("alt_int not sent in status byte");

  latch_set_a: assert property (
    done_rise && irq_en |=> id_measure_done_latch && alt_r)
    else $error("conversion latch not set");

  read_turn_a: assert property (
    cmd_rd |-> ##1 ulpi_nxt ##1 (ulpi_dir && !ulpi_nxt) ##1
    (ulpi_data_oe && ulpi_data_out == $past(rd_mux, 2)) ##1 !ulpi_dir)
    else $error("register read sequence broken");

  idc_set_a: assert property (
    wr_idc && addr_r == uvt_pkg::A_IDC_SET && !cif.done_pls |=>
    (idc_r & $past(wmask)) == $past(wmask))
    else $error("set access did not set bits");

  wr_cov: cover property (wr_go);
  rd_cov: cover property (rd_take && idc_hit(addr_r));
  rx_cov: cover property (rx_sent);
  latch_cov: cover property (done_rise && irq_en);
endmodule : uvt_regs

/* File: bench/uvt_link_model.sv */
// Behavioural ULPI link controller issuing immediate register accesses.
`timescale 1ns/1ns
module uvt_link_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // ULPI link pins
  output logic [7:0] ulpi_data_in,
  input wire logic [7:0] ulpi_data_out,
  input wire logic ulpi_data_oe,
  input wire logic ulpi_dir,
  input wire logic ulpi_nxt,
  output logic ulpi_stp,
  // Observed results
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic [7:0] rx_last,
  output int rx_cnt,
  output logic timeout_flag
);
  logic rd_busy;

  initial begin
    ulpi_data_in = 8'h00;
    ulpi_stp = 1'b0;
    rd_valid = 1'b0;
    rd_data = 8'h00;
    rx_last = 8'h00;
    rx_cnt = 0;
    timeout_flag = 1'b0;
    rd_busy = 1'b0;
  end

  // Bytes the device drives on its own are receive commands.
  always @(negedge core_clk) begin
    if (ulpi_data_oe === 1'b1 && !rd_busy) begin
      rx_last <= ulpi_data_out;
      rx_cnt <= rx_cnt + 1;
    end
  end

  task automatic wait_idle();
    int n;
    n = 0;
    while (ulpi_dir !== 1'b0 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 50) timeout_flag = 1'b1;
  endtask : wait_idle

  // immediate command handshake
  // The command is held until nxt; a bus turnaround restarts it.
  task automatic send_cmd(input logic [7:0] cmd);
    int n;
    n = 0;
    wait_idle();
    ulpi_data_in = cmd;
    @(negedge core_clk);
    while (ulpi_nxt !== 1'b1 && n < 50) begin
      if (ulpi_dir === 1'b1) begin
        ulpi_data_in = ~cmd;
        wait_idle();
        ulpi_data_in = cmd;
      end
      @(negedge core_clk);
      n++;
    end
    if (n >= 50) timeout_flag = 1'b1;
  endtask : send_cmd

  task automatic reg_wr(input logic [5:0] addr, input logic [7:0] val);
    send_cmd({uvt_pkg::CMD_WR, addr});
    @(negedge core_clk);
    ulpi_data_in = val;
    @(negedge core_clk);
    ulpi_stp = 1'b1;
    ulpi_data_in = 8'h00;
    @(negedge core_clk);
    ulpi_stp = 1'b0;
  endtask : reg_wr

  // While the device owns the bus the released lines show the inverse.
  task automatic reg_rd(input logic [5:0] addr);
    int n;
    n = 0;
    send_cmd({uvt_pkg::CMD_RD, addr});
    @(negedge core_clk);
    rd_busy = 1'b1;
    ulpi_data_in = ~{uvt_pkg::CMD_RD, addr};
    while (ulpi_data_oe !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 20) timeout_flag = 1'b1;
    rd_data = ulpi_data_out;
    rd_valid = 1'b1;
    @(negedge core_clk);
    rd_valid = 1'b0;
    wait_idle();
    rd_busy = 1'b0;
    ulpi_data_in = 8'h00;
  endtask : reg_rd
endmodule : uvt_link_model

/* File: bench/test_ulpi_phy_vendor_tuning_regs.sv */
// Self-checking bench for the ULPI vendor tuning register bank.
`timescale 1ns/1ns
module test_ulpi_phy_vendor_tuning_regs;
  localparam int CONV = 20;
  localparam logic [5:0] ZADDR [9] = '{6'h31, 6'h32, 6'h33, 6'h36, 6'h37,
    6'h38, 6'h34, 6'h3F, 6'h20};
  logic core_clk;
  logic srst;
  logic [7:0] ulpi_data_in;
  logic [7:0] ulpi_data_out;
  logic ulpi_data_oe;
  logic ulpi_dir;
  logic ulpi_nxt;
  logic ulpi_stp;
  logic [1:0] line_state_raw;
  logic dp_cmp_raw;
  logic dm_cmp_raw;
  logic [2:0] id_meas_code_raw;
  logic carkit_irq_en;
  logic carkit_latch_rd;
  logic charger_comparator_out;
  logic [2:0] id_resistance_code;
  logic id_measure_done;
  logic id_measure_done_latch;
  logic [1:0] squelch_threshold_trim;
  logic [2:0] hs_drive_boost;
  logic [2:0] dp_lane_en;
  logic [2:0] dm_lane_en;
  logic charging_host_port_sel;
  logic headset_audio_en;
  logic rd_valid;
  logic [7:0] rd_data;
  logic [7:0] rx_last;
  int rx_cnt;
  logic timeout_flag;
  logic [7:0] exp_q[$];
  int err_count = 0;
  int checked = 0;
  int seed = 31;
  logic [7:0] v;

  uvt_regs #(.CONV_CYCLES(CONV)) u_uvt_regs (
    .core_clk(core_clk), .srst(srst), .ulpi_data_in(ulpi_data_in),
    .ulpi_data_out(ulpi_data_out), .ulpi_data_oe(ulpi_data_oe),
    .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt), .ulpi_stp(ulpi_stp),
    .line_state_raw(line_state_raw), .dp_cmp_raw(dp_cmp_raw),
    .dm_cmp_raw(dm_cmp_raw), .id_meas_code_raw(id_meas_code_raw),
    .carkit_irq_en(carkit_irq_en), .carkit_latch_rd(carkit_latch_rd),
    .charger_comparator_out(charger_comparator_out),
    .id_resistance_code(id_resistance_code),
    .id_measure_done(id_measure_done),
    .id_measure_done_latch(id_measure_done_latch),
    .squelch_threshold_trim(squelch_threshold_trim),
    .hs_drive_boost(hs_drive_boost), .dp_lane_en(dp_lane_en),
    .dm_lane_en(dm_lane_en), .charging_host_port_sel(charging_host_port_sel),
    .headset_audio_en(headset_audio_en));

  uvt_link_model u_uvt_link_model (
    .core_clk(core_clk), .srst(srst), .ulpi_data_in(ulpi_data_in),
    .ulpi_data_out(ulpi_data_out), .ulpi_data_oe(ulpi_data_oe),
    .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt), .ulpi_stp(ulpi_stp),
    .rd_valid(rd_valid), .rd_data(rd_data), .rx_last(rx_last),
    .rx_cnt(rx_cnt), .timeout_flag(timeout_flag));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  always @(posedge timeout_flag) begin
    err_count++;
    conclude();
  end

  // Read data is compared against the oldest expectation.
  always @(posedge core_clk) begin
    if (rd_valid === 1'b1 && exp_q.size() > 0) begin
      check(rd_data, exp_q.pop_front());
    end
  end

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_uvt_link_model.reg_rd(a);
  endtask : rd

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    u_uvt_link_model.reg_wr(a, d);
  endtask : wr

  task automatic chg_case(input logic [7:0] wv, input logic dp,
    input logic dm, input logic [1:0] ls, input logic [7:0] e);
    wr(uvt_pkg::A_CHG, wv);
    dp_cmp_raw = dp;
    dm_cmp_raw = dm;
    line_state_raw = ls;
    repeat (5) @(negedge core_clk);
    rd(uvt_pkg::A_CHG, e);
    check({7'h00, charger_comparator_out}, {7'h00, e[4]});
    check({7'h00, charging_host_port_sel}, {7'h00, wv[3]});
    check({5'h00, dp_lane_en}, wv[3] ? 8'h00 : {5'h00, wv[2:0]});
    check({5'h00, dm_lane_en}, wv[3] ? {5'h00, wv[2:0]} : 8'h00);
  endtask : chg_case

  task automatic wait_done();
    int n;
    n = 0;
    while (id_measure_done !== 1'b1 && n < CONV + 40) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= CONV + 40) begin
      err_count++;
      conclude();
    end
    repeat (6) @(negedge core_clk);
  endtask : wait_done

  task automatic latch_read();
    carkit_latch_rd = 1'b1;
    @(negedge core_clk);
    carkit_latch_rd = 1'b0;
    @(negedge core_clk);
  endtask : latch_read

  initial begin
    srst = 1'b1;
    line_state_raw = 2'h0;
    dp_cmp_raw = 1'b0;
    dm_cmp_raw = 1'b0;
    id_meas_code_raw = 3'h0;
    carkit_irq_en = 1'b0;
    carkit_latch_rd = 1'b0;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    @(negedge core_clk);
    foreach (ZADDR[i]) rd(ZADDR[i], 8'h00);
    wr(6'h20, 8'h73);
    wr(6'h34, 8'hFF);
    rd(uvt_pkg::A_TRIM, 8'h00);
    rd(6'h34, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      v[6:4] = i[2:0];
      v[1:0] = i[1:0];
      wr(uvt_pkg::A_TRIM, v);
      rd(uvt_pkg::A_TRIM, v & 8'h73);
      check({6'h00, squelch_threshold_trim}, {6'h00, v[1:0]});
      check({5'h00, hs_drive_boost}, {5'h00, v[6:4]});
    end
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      if (i[0] == 1'b0) v[3:0] = 4'hA;
      wr(uvt_pkg::A_HSET, v);
      rd(uvt_pkg::A_HSET, {4'h0, v[3:0]});
      check({7'h00, headset_audio_en}, {7'h00, v[3:0] == 4'hA});
    end
    chg_case(8'h0E, 1'b0, 1'b1, 2'h0, 8'h1E);
    chg_case(8'h0E, 1'b1, 1'b0, 2'h0, 8'h0E);
    chg_case(8'h07, 1'b1, 1'b0, 2'h0, 8'h17);
    chg_case(8'h02, 1'b1, 1'b0, 2'h2, 8'h02);
    chg_case(8'h01, 1'b1, 1'b1, 2'h0, 8'h01);
    chg_case(8'h00, 1'b0, 1'b0, 2'h1, 8'h00);
    id_meas_code_raw = 3'h5;
    wr(uvt_pkg::A_IDC, 8'h50);
    rd(uvt_pkg::A_IDC, 8'h50);
    wait_done();
    check(8'(rx_cnt), 8'h01);
    check(rx_last, 8'h81);
    check({5'h00, id_resistance_code}, 8'h05);
    check({7'h00, id_measure_done_latch}, 8'h01);
    latch_read();
    check({7'h00, id_measure_done_latch}, 8'h00);
    check({7'h00, id_measure_done}, 8'h01);
    rd(uvt_pkg::A_IDC_SET, 8'h4D);
    check({7'h00, id_measure_done}, 8'h00);
    wr(uvt_pkg::A_IDC_CLR, 8'h40);
    rd(uvt_pkg::A_IDC, 8'h05);
    carkit_irq_en = 1'b1;
    id_meas_code_raw = 3'h3;
    wr(uvt_pkg::A_IDC_SET, 8'h10);
    wait_done();
    check(8'(rx_cnt), 8'h02);
    rd(uvt_pkg::A_IDC_CLR, 8'h0B);
    carkit_irq_en = 1'b0;
    latch_read();
    id_meas_code_raw = 3'h7;
    wr(uvt_pkg::A_IDC_SET, 8'h10);
    wait_done();
    check(8'(rx_cnt), 8'h02);
    check({7'h00, id_measure_done_latch}, 8'h00);
    rd(uvt_pkg::A_IDC, 8'h0F);
    check(8'(exp_q.size()), 8'h00);
    conclude();
  end
endmodule : test_ulpi_phy_vendor_tuning_regs
